// >>> mrs_defs.svh
/*
  constants of the modbus rtu slave function block: function and
  exception codes, frame limits, crc seed and buffer depths.
  assumes it is included by bare name, once per compilation unit.
*/
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH

// function codes handled here
`define MRS_FN_DIAG 8'h08
`define MRS_FN_WRMULTI 8'h10
`define MRS_FN_LOG 8'h46
// exception frame marking and codes
`define MRS_EXC_FLAG 8'h80
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_DATA 8'h03
// addresses and field values
`define MRS_BCAST 8'h00
`define MRS_SUB_ECHO 16'h0000
`define MRS_MAX_WORDS 16'h007d
`define MRS_BC_MIN 8'h02
`define MRS_BC_MAX 8'hfa
// frame lengths in bytes, crc included
`define MRS_MIN_LEN 9'h004
`define MRS_DIAG_LEN 9'h008
`define MRS_LOG_LEN 9'h004
`define MRS_WRM_HDR 9'h009
`define MRS_LEN_MAX 9'h1ff
// crc-16, reflected polynomial, low byte sent first
`define MRS_CRC_INIT 16'hffff
`define MRS_CRC_POLY 16'ha001
// header bytes kept, reply body bytes, buffer depths
`define MRS_HDR_BYTES 7
`define MRS_REP_MAX 6
`define MRS_STG_DEPTH 128
`define MRS_TX_DEPTH 8

`endif

// >>> mrs_pkg.sv
/*
  types shared by the modbus rtu slave block, its checker and its bench.
  assumes mrs_defs.svh is found on the include path.
*/
package mrs_pkg;

  // controller states
  typedef enum logic [1:0] {
    mrs_st_idle  = 2'b00,
    mrs_st_check = 2'b01,
    mrs_st_write = 2'b10,
    mrs_st_reply = 2'b11
  } mrs_state_t;

  // one received character with its line errors
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity_err;
    logic framing_err;
    logic overrun_err;
  } mrs_rx_byte_t;

  // holding register write toward the register map
  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [15:0] data;
  } mrs_wr_t;

endpackage

// >>> mrs_fifo.sv
/*
  synchronous fifo with valid/ready on both sides and registered read
  data. assumes a power-of-two depth and a single clock domain.
*/
`timescale 1ns/1ps
module mrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ***************************************************
  // parameter check
  // ***************************************************
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("mrs_fifo needs a power-of-two depth of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // clear wins over a push in the same cycle
  // full level needs the extra count bit, depth itself does not fit in AW
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready && !clr;
  assign pop = out_ready && out_valid && !clr;
  assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;

  // storage array, no reset needed
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (clr) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        count_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= wr_ptr_r + 1'b1;
        end
        rd_ptr_r <= rd_ptr_nxt;
        count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  // head word held in a flop; bypass covers a write into the slot read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
    end else if (ce) begin
      if (push && wr_ptr_r == rd_ptr_nxt) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[rd_ptr_nxt];
      end
    end
  end

endmodule // mrs_fifo

// >>> mrs_modbus_slave.sv
/*
  modbus rtu slave message handling: diagnostic echo, write of multiple
  holding registers, access-log read, exception replies and silent
  drops. assumes a uart in front that delivers characters with their
  line errors and marks the end of each frame by a one-cycle pulse that
  never coincides with a character; the register map answers wr_ok for
  the address on wr_out.addr in the same cycle.
*/
`timescale 1ns/1ps
`include "mrs_defs.svh"
module mrs_modbus_slave
  import mrs_pkg::*;
#(
  parameter int STG_DEPTH = `MRS_STG_DEPTH,
  parameter int TX_DEPTH = `MRS_TX_DEPTH,
  parameter int ERR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] station_addr,
  input wire mrs_rx_byte_t rx_in,
  input wire logic frame_end,
  output mrs_wr_t wr_out,
  input wire logic wr_ok,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [ERR_W-1:0] comm_error_count,
  output logic comm_error_output
);

  // ***************************************************
  // parameter check
  // ***************************************************
  generate
    if (STG_DEPTH < 128 || TX_DEPTH < 8 || ERR_W < 1) begin : g_bad
      $error("mrs_modbus_slave buffers too small for the longest frame");
    end
  endgenerate

  // crc-16 of one byte, reflected
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ***************************************************
  // declarations
  // ***************************************************
  mrs_state_t state_r;
  logic [8:0] idx_r;
  logic [15:0] rx_crc_r;
  logic line_err_r;
  logic drop_r;
  logic [7:0] hi_r;
  logic [7:0] hdr_r [`MRS_HDR_BYTES];
  logic [8:0] len_r;
  logic idle;
  logic rx_take;
  logic stg_push;
  logic stg_clr;
  logic stg_in_ready;
  logic stg_valid;
  logic stg_pop;
  logic [15:0] stg_data;
  logic frame_bad;
  logic frame_go;
  logic [7:0] rep_r [`MRS_REP_MAX];
  logic [3:0] rep_len_r;
  logic [3:0] tx_idx_r;
  logic [15:0] tx_crc_r;
  logic [7:0] tx_byte;
  logic tx_push;
  logic tx_in_ready;
  logic [15:0] wr_addr_r;
  logic [15:0] wr_left_r;
  logic [15:0] succ_cnt_r;
  logic [15:0] succ_sa_r;
  logic bcast_r;
  logic [15:0] log_sa_r;
  logic [15:0] log_cnt_r;
  logic [7:0] q_addr;
  logic [7:0] q_fn;
  logic [15:0] q_start;
  logic [15:0] q_cnt;
  logic [7:0] q_bc;

  assign idle = (state_r == mrs_st_idle);
  assign rx_take = rx_in.valid && idle && !drop_r;
  assign q_addr = hdr_r[0];
  assign q_fn = hdr_r[1];
  assign q_start = {hdr_r[2], hdr_r[3]};
  assign q_cnt = {hdr_r[4], hdr_r[5]};
  assign q_bc = hdr_r[6];

  // ***************************************************
  // frame collection
  // ***************************************************

  // byte index, running crc and line errors of the frame being received
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idx_r <= '0;
      rx_crc_r <= `MRS_CRC_INIT;
      line_err_r <= 1'b0;
      drop_r <= 1'b0;
      hi_r <= '0;
    end else if (ce) begin
      if (frame_end) begin
        idx_r <= '0;
        rx_crc_r <= `MRS_CRC_INIT;
        line_err_r <= 1'b0;
        drop_r <= 1'b0;
      end else if (rx_in.valid) begin
        if (!idle) begin
          drop_r <= 1'b1;
        end
        line_err_r <= line_err_r | rx_in.parity_err | rx_in.framing_err
                      | rx_in.overrun_err;
        rx_crc_r <= crc_byte(rx_crc_r, rx_in.data);
        if (idx_r != `MRS_LEN_MAX) begin
          idx_r <= idx_r + 9'h001;
        end
        if (idx_r[0]) begin
          hi_r <= rx_in.data;
        end
      end
    end
  end

  // header bytes are only taken while idle so a reply in progress keeps them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MRS_HDR_BYTES; i++) begin
        hdr_r[i] <= '0;
      end
    end else if (ce) begin
      if (rx_take && idx_r < 9'(`MRS_HDR_BYTES)) begin
        hdr_r[idx_r[2:0]] <= rx_in.data;
      end
    end
  end

  // data words staged until the crc proves the frame good
  assign stg_push = rx_take && idx_r >= 9'h008 && !idx_r[0];
  assign stg_clr = rx_take && idx_r == 9'h000;
  assign stg_pop = (state_r == mrs_st_write) && stg_valid
                   && wr_left_r != 16'h0000;

  mrs_fifo #(
    .WIDTH(16),
    .DEPTH(STG_DEPTH)
  ) u_stage (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .clr(stg_clr),
    .in_valid(stg_push),
    .in_ready(stg_in_ready),
    .in_data({hi_r, rx_in.data}),
    .out_valid(stg_valid),
    .out_ready(stg_pop),
    .out_data(stg_data)
  );

  // line error, short frame or crc mismatch; residue is zero when good
  assign frame_bad = line_err_r || idx_r < `MRS_MIN_LEN
                     || rx_crc_r != 16'h0000;
  assign frame_go = frame_end && idle && !drop_r && !frame_bad;

  // ***************************************************
  // error counting
  // ***************************************************

  // counter saturates; output stays up until a good frame arrives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comm_error_count <= '0;
      comm_error_output <= 1'b0;
    end else if (ce) begin
      if (frame_end && idle && !drop_r && frame_bad) begin
        if (comm_error_count != {ERR_W{1'b1}}) begin
          comm_error_count <= comm_error_count + 1'b1;
        end
        comm_error_output <= 1'b1;
      end else if (frame_go) begin
        comm_error_output <= 1'b0;
      end
    end
  end

  // ***************************************************
  // decode, write and reply sequencing
  // ***************************************************

  // one process owns the state and everything it decides
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= mrs_st_idle;
      len_r <= '0;
      rep_len_r <= '0;
      for (int i = 0; i < `MRS_REP_MAX; i++) begin
        rep_r[i] <= '0;
      end
      wr_addr_r <= '0;
      wr_left_r <= '0;
      succ_cnt_r <= '0;
      succ_sa_r <= '0;
      bcast_r <= 1'b0;
      log_sa_r <= '0;
      log_cnt_r <= '0;
    end else if (ce) begin
      unique case (state_r)
        mrs_st_idle: begin
          if (frame_go) begin
            len_r <= idx_r;
            state_r <= mrs_st_check;
          end
        end
        mrs_st_check: begin
          // reply body defaults to the echoed header
          rep_r[0] <= q_addr;
          rep_r[1] <= q_fn;
          rep_r[2] <= hdr_r[2];
          rep_r[3] <= hdr_r[3];
          rep_r[4] <= hdr_r[4];
          rep_r[5] <= hdr_r[5];
          rep_len_r <= 4'h6;
          bcast_r <= (q_addr == `MRS_BCAST);
          state_r <= mrs_st_reply;
          if (q_addr != `MRS_BCAST && q_addr != station_addr) begin
            state_r <= mrs_st_idle;
          end else if (q_fn == `MRS_FN_DIAG) begin
            log_sa_r <= '0;
            log_cnt_r <= '0;
            if (q_addr == `MRS_BCAST) begin
              state_r <= mrs_st_idle;
            end else if (len_r != `MRS_DIAG_LEN) begin
              rep_r[1] <= q_fn | `MRS_EXC_FLAG;
              rep_r[2] <= `MRS_EXC_DATA;
              rep_len_r <= 4'h3;
            end else if (q_start != `MRS_SUB_ECHO) begin
              rep_r[1] <= q_fn | `MRS_EXC_FLAG;
              rep_r[2] <= `MRS_EXC_FUNC;
              rep_len_r <= 4'h3;
            end
            // otherwise the six bytes already loaded are the echo
          end else if (q_fn == `MRS_FN_WRMULTI) begin
            if (len_r != `MRS_WRM_HDR + {1'b0, q_bc}
                || q_cnt == 16'h0000 || q_cnt > `MRS_MAX_WORDS
                || q_bc < `MRS_BC_MIN || q_bc > `MRS_BC_MAX
                || {q_cnt[14:0], 1'b0} != {8'h00, q_bc}) begin
              log_sa_r <= '0;
              log_cnt_r <= '0;
              rep_r[1] <= q_fn | `MRS_EXC_FLAG;
              rep_r[2] <= `MRS_EXC_DATA;
              rep_len_r <= 4'h3;
              if (q_addr == `MRS_BCAST) begin
                state_r <= mrs_st_idle;
              end
            end else begin
              wr_addr_r <= q_start;
              wr_left_r <= q_cnt;
              succ_cnt_r <= '0;
              succ_sa_r <= '0;
              state_r <= mrs_st_write;
            end
          end else if (q_fn == `MRS_FN_LOG) begin
            if (q_addr == `MRS_BCAST) begin
              state_r <= mrs_st_idle;
            end else if (len_r != `MRS_LOG_LEN) begin
              rep_r[1] <= q_fn | `MRS_EXC_FLAG;
              rep_r[2] <= `MRS_EXC_DATA;
              rep_len_r <= 4'h3;
            end else begin
              rep_r[2] <= log_sa_r[15:8];
              rep_r[3] <= log_sa_r[7:0];
              rep_r[4] <= log_cnt_r[15:8];
              rep_r[5] <= log_cnt_r[7:0];
            end
          end else begin
            log_sa_r <= '0;
            log_cnt_r <= '0;
            rep_r[1] <= q_fn | `MRS_EXC_FLAG;
            rep_r[2] <= `MRS_EXC_FUNC;
            rep_len_r <= 4'h3;
            if (q_addr == `MRS_BCAST) begin
              state_r <= mrs_st_idle;
            end
          end
        end
        mrs_st_write: begin
          if (stg_pop) begin
            wr_addr_r <= wr_addr_r + 16'h0001;
            wr_left_r <= wr_left_r - 16'h0001;
            if (wr_ok) begin
              succ_cnt_r <= succ_cnt_r + 16'h0001;
              if (succ_cnt_r == 16'h0000) begin
                succ_sa_r <= wr_addr_r;
              end
            end
          end else if (wr_left_r == 16'h0000) begin
            log_sa_r <= succ_sa_r;
            log_cnt_r <= succ_cnt_r;
            state_r <= bcast_r ? mrs_st_idle : mrs_st_reply;
            if (succ_cnt_r == 16'h0000) begin
              rep_r[1] <= q_fn | `MRS_EXC_FLAG;
              rep_r[2] <= `MRS_EXC_ADDR;
              rep_len_r <= 4'h3;
            end
            // else the header loaded in check is the normal reply
          end
        end
        mrs_st_reply: begin
          if (tx_push && tx_idx_r == rep_len_r + 4'h1) begin
            state_r <= mrs_st_idle;
          end
        end
        default: begin
          state_r <= mrs_st_idle;
        end
      endcase
    end
  end

  // write strobe is combinational so wr_ok of the same cycle decides it
  assign wr_out.en = stg_pop && wr_ok;
  assign wr_out.addr = wr_addr_r;
  assign wr_out.data = stg_data;

  // ***************************************************
  // reply transmission
  // ***************************************************

  // body bytes, then crc low byte, then crc high byte
  always_comb begin
    if (tx_idx_r < rep_len_r) begin
      tx_byte = rep_r[tx_idx_r[2:0]];
    end else if (tx_idx_r == rep_len_r) begin
      tx_byte = tx_crc_r[7:0];
    end else begin
      tx_byte = tx_crc_r[15:8];
    end
  end

  assign tx_push = (state_r == mrs_st_reply) && tx_in_ready;

  // the fifo stalls this walk when the uart falls behind
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_idx_r <= '0;
      tx_crc_r <= `MRS_CRC_INIT;
    end else if (ce) begin
      if (state_r != mrs_st_reply) begin
        tx_idx_r <= '0;
        tx_crc_r <= `MRS_CRC_INIT;
      end else if (tx_push) begin
        tx_idx_r <= tx_idx_r + 4'h1;
        if (tx_idx_r < rep_len_r) begin
          tx_crc_r <= crc_byte(tx_crc_r, tx_byte);
        end
      end
    end
  end

  mrs_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .clr(1'b0),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(tx_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

endmodule // mrs_modbus_slave

// >>> mrs_modbus_slave_checker.sv
/*
  port checker of the modbus slave block, bound into every instance.
  assumes single clock domain and the port timing of the hand-over.
*/
`timescale 1ns/1ps
module mrs_modbus_slave_checker
  import mrs_pkg::*;
#(
  parameter int ERR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] station_addr,
  input wire mrs_rx_byte_t rx_in,
  input wire logic frame_end,
  input wire mrs_wr_t wr_out,
  input wire logic wr_ok,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [ERR_W-1:0] comm_error_count,
  input wire logic comm_error_output
);
  // ****************************************************
  // properties
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // two register writes on adjacent cycles
  sequence s_burst;
    wr_out.en ##1 wr_out.en;
  endsequence
  // reply byte offered but not taken
  sequence s_stall;
    ce && tx_valid && !tx_ready;
  endsequence
  a_reset_quiet: assert property ($fell(rst) |->
    !tx_valid && !comm_error_output && comm_error_count == '0)
    else $error("outputs not idle after reset");
  a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
    else $error("reply byte lost while stalled");
  a_err_step: assert property ($changed(comm_error_count) |->
    comm_error_count == $past(comm_error_count) + 1'b1)
    else $error("error count moved by other than one");
  a_err_flag: assert property ($changed(comm_error_count) |->
    comm_error_output)
    else $error("error output low after an error");
  a_wr_gated: assert property (wr_out.en |-> wr_ok)
    else $error("write to locked register");
  a_wr_consec: assert property (s_burst |->
    wr_out.addr == $past(wr_out.addr) + 16'h1)
    else $error("write addresses not consecutive");
  a_reply_gap: assert property ($rose(tx_valid) |->
    !$past(frame_end) && !$past(frame_end, 2))
    else $error("reply before frame was checked");
  a_ce_freeze: assert property (!ce |=>
    $stable(comm_error_count) && $stable(tx_data))
    else $error("state moved with clock enable low");
endmodule // mrs_modbus_slave_checker

bind mrs_modbus_slave mrs_modbus_slave_checker #(.ERR_W(ERR_W)) chk (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .station_addr(station_addr),
  .rx_in(rx_in), .frame_end(frame_end), .wr_out(wr_out), .wr_ok(wr_ok),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .comm_error_count(comm_error_count),
  .comm_error_output(comm_error_output)
);

// >>> mrs_master_model.sv
/*
  reply side of the bus master: takes reply bytes with stalls.
  assumes the testbench reads the got queue by hierarchy.
*/
`timescale 1ns/1ps
module mrs_master_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic [3:0] stall_r;
  // stall pattern so reply bytes queue up in the reply fifo
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) stall_r <= 4'h9;
    else stall_r <= {stall_r[2:0], stall_r[3] ^ stall_r[2]};
  end
  assign tx_ready = stall_r[0];
  // a byte moves only on an enabled handshake edge
  always @(posedge sys_clk) begin
    if (!rst && ce && tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule // mrs_master_model

// >>> tb_mrs_modbus_slave.sv
/*
  self-checking bench of the modbus slave block with a bench-side
  register map that locks addresses with bit 15 set.
  assumes the bus master model file is compiled before it.
*/
`timescale 1ns/1ps
`include "mrs_defs.svh"
module tb_mrs_modbus_slave import mrs_pkg::*;;
  logic sys_clk = 0, rst = 1, ce = 1, frame_end = 0;
  logic [7:0] station_addr = 8'h19;
  mrs_rx_byte_t rx_in = '0;
  mrs_wr_t wr_out;
  logic wr_ok, tx_valid, tx_ready, comm_error_output;
  logic [7:0] tx_data;
  logic [15:0] comm_error_count, lf = 16'hec7e;
  logic [7:0] exp_q[$];
  logic [31:0] wexp_q[$], wgot_q[$];
  int num_errors = 0, samples_checked = 0, exp_err = 0;
  // ****************************************************
  // design, partner and register map
  // ****************************************************
  mrs_modbus_slave dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .station_addr(station_addr), .rx_in(rx_in), .frame_end(frame_end),
    .wr_out(wr_out), .wr_ok(wr_ok), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready),
    .comm_error_count(comm_error_count),
    .comm_error_output(comm_error_output));
  mrs_master_model master (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  assign wr_ok = ~wr_out.addr[15];
  // record every write the map accepts
  always @(posedge sys_clk) begin
    if (!rst && ce && wr_out.en) wgot_q.push_back({wr_out.addr, wr_out.data});
  end
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [15:0] crc(logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one char per two cycles; bad flips the crc, perr marks byte 1
  task automatic send(logic [7:0] q[$], bit bad, bit perr);
    logic [15:0] c;
    c = crc(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge sys_clk);
      rx_in <= '{1'b1, q[i], perr && (i == 1), 1'b0, 1'b0};
      @(negedge sys_clk);
      rx_in <= '0;
    end
    @(negedge sys_clk);
    frame_end <= 1'b1;
    @(negedge sys_clk);
    frame_end <= 1'b0;
  endtask
  task automatic want(logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    foreach (q[i]) exp_q.push_back(q[i]);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask
  // wait out the reply, then compare bytes, writes and errors
  task automatic finish_frame();
    int n;
    n = 0;
    while (master.got.size() < exp_q.size() && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (30) @(negedge sys_clk);
    check(master.got.size(), exp_q.size());
    foreach (exp_q[i]) check(master.got[i], exp_q[i]);
    check(wgot_q.size(), wexp_q.size());
    foreach (wexp_q[i]) check(wgot_q[i], wexp_q[i]);
    check(comm_error_count, exp_err);
    master.got.delete();
    exp_q.delete();
    wexp_q.delete();
    wgot_q.delete();
  endtask
  task automatic exc(logic [7:0] q[$], logic [7:0] code);
    logic [7:0] r[$];
    send(q, 0, 0);
    r = {q[0], q[1] | 8'h80, code};
    want(r);
    finish_frame();
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: whole run is well under this span
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
  // ****************************************************
  // scenarios
  // ****************************************************
  initial begin
    logic [7:0] d[$];
    logic [15:0] w[3];
    repeat (8) @(negedge sys_clk);
    rst <= 1'b0;
    // write of three words, the last one on a locked register
    foreach (w[i]) w[i] = rnd();
    d = {8'h19, 8'h10, 8'h7f, 8'hfe, 8'h00, 8'h03, 8'h06, w[0][15:8],
      w[0][7:0], w[1][15:8], w[1][7:0], w[2][15:8], w[2][7:0]};
    send(d, 0, 0);
    wexp_q.push_back({16'h7ffe, w[0]});
    wexp_q.push_back({16'h7fff, w[1]});
    d = {8'h19, 8'h10, 8'h7f, 8'hfe, 8'h00, 8'h03};
    want(d);
    finish_frame();
    d = {8'h19, 8'h46};
    send(d, 0, 0);
    d = {8'h19, 8'h46, 8'h7f, 8'hfe, 8'h00, 8'h02};
    want(d);
    finish_frame();
    // echo of random data and the top of the range
    for (int k = 0; k < 3; k++) begin
      w[0] = (k == 2) ? 16'hffff : rnd();
      d = {8'h19, 8'h08, 8'h00, 8'h00, w[0][15:8], w[0][7:0]};
      send(d, 0, 0);
      want(d);
      finish_frame();
    end
    d = {8'h19, 8'h46};
    send(d, 0, 0);
    d = {8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00};
    want(d);
    finish_frame();
    // exception replies
    d = {8'h19, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    exc(d, 8'h01);
    d = {8'h19, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34};
    exc(d, 8'h01);
    d = {8'h19, 8'h08, 8'h00, 8'h00, 8'h12};
    exc(d, 8'h03);
    d = {8'h19, 8'h46, 8'h00};
    exc(d, 8'h03);
    d = {8'h19, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'haa, 8'hbb,
      8'hcc, 8'hdd};
    exc(d, 8'h03);
    d = {8'h19, 8'h10, 8'h00, 8'h00, 8'h00, 8'h7e, 8'hfc};
    exc(d, 8'h03);
    d = {8'h19, 8'h10, 8'h80, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
    exc(d, 8'h02);
    // broadcast and foreign station: silence, broadcast write done
    d = {8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'hab, 8'hcd};
    send(d, 0, 0);
    wexp_q.push_back({16'h0010, 16'habcd});
    finish_frame();
    d = {8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    send(d, 0, 0);
    finish_frame();
    d = {8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    send(d, 0, 0);
    finish_frame();
    d = {8'h22, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    send(d, 0, 0);
    finish_frame();
    // reception errors: bad crc, parity, short frame
    d = {8'h19, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    send(d, 1, 0);
    exp_err++;
    finish_frame();
    send(d, 0, 1);
    exp_err++;
    finish_frame();
    d = {8'h19};
    send(d, 0, 0);
    exp_err++;
    finish_frame();
    check(comm_error_output, 1'b1);
    ce <= 1'b0;
    repeat (3) @(negedge sys_clk);
    ce <= 1'b1;
    d = {8'h19, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    send(d, 0, 0);
    want(d);
    finish_frame();
    check(comm_error_output, 1'b0);
    report_and_stop();
  end
endmodule // tb_mrs_modbus_slave
